// >>> rts_pkg.sv
`default_nettype none
package rts_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int CLK_NS = 8;
  localparam int POWER_UP_TIMER_MS = 64;
  localparam int POWER_UP_TIMER_CYC = POWER_UP_TIMER_MS * 1000 * CLK_MHZ;
  localparam int OST_PERIODS = 1024;
  localparam int BOR_MIN_NS = 100;
  localparam int BOR_MIN_CYC = (BOR_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int PIN_FILT_NS = 2000;
  localparam int PIN_FILT_CYC = (PIN_FILT_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // Register map (indices; byte address is index times four)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_KEEP = 8'h01;
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam logic [7:0] IDX_CAL = 8'h10;
  localparam logic [7:0] IDX_POWER_CONTROL_FLAGS = 8'h8e;
  localparam logic [15:0] CALIB_WORD_ADDR = 16'h2008;
  localparam int POWER_CONTROL_FLAGS_BOR_BIT = 0;
  localparam int POWER_CONTROL_FLAGS_POR_BIT = 1;
  localparam int ST_PD_BIT = 3;
  localparam int ST_TO_BIT = 4;
  localparam logic [7:0] KEEP_RST = 8'h00;
  localparam logic POWER_CONTROL_FLAGS_POR_RST = 1'b0;
  localparam logic POWER_CONTROL_FLAGS_BOR_RST = 1'b0;
  localparam logic STAT_RST = 1'b1;

  // ----------------------------------------------------------------
  // Configuration encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] OSC_LP = 3'h0;
  localparam logic [2:0] OSC_XT = 3'h1;
  localparam logic [2:0] OSC_HS = 3'h2;
  localparam logic [1:0] BORM_OFF = 2'h0;
  localparam logic [1:0] BORM_SLEEP_OFF = 2'h2;

  typedef enum logic [2:0] {
    ST_HOLD, ST_POWER_UP_TIMER, ST_OST, ST_PIN, ST_RUN, ST_WAKE
  } rts_state_e;
endpackage
`default_nettype wire

// >>> rts_sequencer.sv
// How it works
// - Calibration word is captured once after system reset and no sequencer reset alters it
// - Six reset causes are told apart through the flag registers
// - Retained register is never touched by any sequencer reset
// - Core reset asserts on power-on, pin, watchdog and brown-out resets
// - Watchdog wake from sleep resumes without any register reset
// - Pin low pulses shorter than the filter time are ignored
// - Watchdog reset stays internal; the reset pin is never driven
// - Pin select 1 enables pin reset and weak pull-up; 0 ignores pin
// - Power-up timer holds reset 64 ms, only after power-on or brown-out
// - Power-up timer disable bit set skips the timer
// - Brown-out mode 00 off, 10 off during sleep, others always on
// - Supply below threshold longer than minimum duration gives brown-out
// - Any reset holds until supply is above threshold unless brown-out detect is off; power-on and brown-out then run the timer
// - Brown-out during timer returns to hold and restarts full count
// - Timer starts after power-on detect ends; crystal count after timer
// - Crystal modes add 1024 oscillator periods after power-on or brown-out, also on sleep wake
// - External clock with timer disabled applies no delay at all
// - Delays run regardless of pin; releasing pin afterwards starts at once
// - Brown-out flag clears on brown-out; software sets it afterwards
// - Power-on flag clears on power-on only; software writes one after
// - Expired and sleep flags follow each reset cause as tabulated
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module rts_sequencer
  import rts_pkg::*;
#(
  parameter int POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic external_reset_pin,
  input wire logic power_on_detect,
  input wire logic supply_above_threshold,
  input wire logic osc_clk_in,
  input wire logic external_reset_pin_select,
  input wire logic power_up_timer_disable_bit,
  input wire logic [1:0] brownout_mode_select,
  input wire logic [2:0] osc_mode,
  input wire logic [7:0] calib_fuse,
  input wire logic watchdog_timeout,
  input wire logic sleep_enter,
  output logic core_reset,
  output logic clock_stall,
  output logic weak_pullup_en,
  output logic brownout_detect_en,
  output logic [7:0] calib_word
);
  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic is_xtal(input logic [2:0] m);
    is_xtal = (m == OSC_LP) || (m == OSC_XT) || (m == OSC_HS);
  endfunction

  function automatic logic hit(input logic [31:0] a,
                               input logic [7:0] idx);
    hit = (a[31:10] == 22'h000000) && (a[9:2] == idx);
  endfunction

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;
  logic [15:0] in_m;
  logic [15:0] in_s;
  logic [15:0] in_raw;
  logic osc_q;

  // Release is synchronised; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign in_raw = {calib_fuse, external_reset_pin_select,
                   power_up_timer_disable_bit, brownout_mode_select,
                   external_reset_pin, power_on_detect,
                   supply_above_threshold, osc_clk_in};

  // Straps and pins all come from outside this clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_m <= 16'h0000;
      in_s <= 16'h0000;
      osc_q <= 1'b0;
    end else begin
      in_m <= in_raw;
      in_s <= in_m;
      osc_q <= in_s[0];
    end
  end

  logic osc_edge, supply_ok, por_s, pin_s, sel_s, power_up_timer_disable_bit_s;
  logic [1:0] borm_s;
  logic [2:0] mode_m;
  logic [2:0] mode_s;
  assign osc_edge = in_s[0] & ~osc_q;
  assign supply_ok = in_s[1];
  assign por_s = in_s[2];
  assign pin_s = in_s[3];
  assign borm_s = in_s[5:4];
  assign power_up_timer_disable_bit_s = in_s[6];
  assign sel_s = in_s[7];

  // Osc mode strap passes two stages like every other pin
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_m <= OSC_LP;
      mode_s <= OSC_LP;
    end else begin
      mode_m <= osc_mode;
      mode_s <= mode_m;
    end
  end

  // ----------------------------------------------------------------
  // Calibration word capture
  // ----------------------------------------------------------------
  logic cal_done;
  logic [1:0] cal_wait;

  // Captured once, after the sync stages hold the fuse and not reset zeros
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_done <= 1'b0;
      cal_wait <= 2'h0;
      calib_word <= 8'h00;
    end else if (!cal_done) begin
      cal_wait <= cal_wait + 2'h1;
      if (cal_wait == 2'h2) begin
        cal_done <= 1'b1;
        calib_word <= in_s[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin filter and brown-out detect
  // ----------------------------------------------------------------
  logic [11:0] pin_cnt;
  logic pin_low;
  logic pin_evt;
  logic [11:0] bor_cnt;
  logic bor_low;
  logic bor_evt;
  logic bor_en;
  logic por_q;
  logic por_evt;
  logic sleeping;
  rts_state_e st;
  rts_state_e next_st;

  // Pin only counts when the select strap makes it a reset input
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_cnt <= 12'h000;
      pin_low <= 1'b0;
    end else if (!(sel_s && !pin_s)) begin
      pin_cnt <= 12'h000;
      pin_low <= 1'b0;
    end else if (pin_cnt == 12'(PIN_FILT_CYC - 1)) begin
      pin_low <= 1'b1;
    end else begin
      pin_cnt <= pin_cnt + 12'h001;
    end
  end
  assign pin_evt = sel_s && !pin_s && !pin_low &&
                   (pin_cnt == 12'(PIN_FILT_CYC - 1));

  // Mode 10 drops detection while asleep to save current
  assign bor_en = (borm_s != BORM_OFF) &&
                  !((borm_s == BORM_SLEEP_OFF) && sleeping);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bor_cnt <= 12'h000;
      bor_low <= 1'b0;
    end else if (!bor_en || supply_ok) begin
      bor_cnt <= 12'h000;
      bor_low <= 1'b0;
    end else if (bor_cnt == 12'(BOR_MIN_CYC - 1)) begin
      bor_low <= 1'b1;
    end else begin
      bor_cnt <= bor_cnt + 12'h001;
    end
  end
  assign bor_evt = bor_en && !supply_ok && !bor_low &&
                   (bor_cnt == 12'(BOR_MIN_CYC - 1));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_q <= 1'b0;
    end else begin
      por_q <= por_s;
    end
  end
  assign por_evt = por_s & ~por_q;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic wdt_evt, wdt_rst, wake, pwr_kind;
  logic [31:0] power_up_timer_cnt;
  logic [10:0] ost_cnt;
  logic hold_ok, power_up_timer_done, ost_done;

  // A timeout outside run is meaningless; it stays internal
  assign wdt_evt = watchdog_timeout && (st == ST_RUN);
  assign wdt_rst = wdt_evt && !sleeping;
  assign wake = wdt_evt && sleeping;
  // Straps are not trusted until the sync stages have filled
  assign hold_ok = cal_done && !por_s && !bor_low && (supply_ok || !bor_en);
  assign power_up_timer_done = (power_up_timer_cnt == 32'(POWER_UP_TIMER_CYCLES - 1));
  assign ost_done = osc_edge && (ost_cnt == 11'(OST_PERIODS - 1));

  always_comb begin
    next_st = st;
    case (st)
      ST_HOLD: begin
        if (hold_ok) begin
          if (pwr_kind && !power_up_timer_disable_bit_s) begin
            next_st = ST_POWER_UP_TIMER;
          end else if (pwr_kind && is_xtal(mode_s)) begin
            next_st = ST_OST;
          end else begin
            next_st = ST_PIN;
          end
        end
      end
      ST_POWER_UP_TIMER: begin
        if (power_up_timer_done) begin
          next_st = is_xtal(mode_s) ? ST_OST : ST_PIN;
        end
      end
      ST_OST: begin
        if (ost_done) begin
          next_st = ST_PIN;
        end
      end
      ST_PIN: begin
        if (!pin_low) begin
          next_st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (wdt_rst || pin_evt) begin
          next_st = ST_HOLD;
        end else if (wake && is_xtal(mode_s)) begin
          next_st = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (pin_evt) begin
          next_st = ST_HOLD;
        end else if (ost_done) begin
          next_st = ST_RUN;
        end
      end
      default: next_st = ST_HOLD;
    endcase
    // Power loss overrides every state, timers included
    if (por_s || bor_low || bor_evt) begin
      next_st = ST_HOLD;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_HOLD;
      pwr_kind <= 1'b1;
      core_reset <= 1'b1;
      clock_stall <= 1'b0;
    end else begin
      st <= next_st;
      core_reset <= (next_st != ST_RUN) && (next_st != ST_WAKE);
      clock_stall <= (next_st == ST_WAKE);
      if (por_evt || bor_evt) begin
        pwr_kind <= 1'b1;
      end else if (wdt_rst || pin_evt) begin
        pwr_kind <= 1'b0;
      end
    end
  end

  // Timer restarts whenever the state is left, so a dip rearms it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_up_timer_cnt <= 32'h0000_0000;
    end else if (st != ST_POWER_UP_TIMER || next_st != ST_POWER_UP_TIMER) begin
      power_up_timer_cnt <= 32'h0000_0000;
    end else begin
      power_up_timer_cnt <= power_up_timer_cnt + 32'h0000_0001;
    end
  end

  // Counts oscillator rising edges, not system cycles
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ost_cnt <= 11'h000;
    end else if (st != ST_OST && st != ST_WAKE) begin
      ost_cnt <= 11'h000;
    end else if (osc_edge) begin
      ost_cnt <= ost_cnt + 11'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleeping <= 1'b0;
    end else if (next_st != ST_RUN && next_st != ST_WAKE) begin
      sleeping <= 1'b0;
    end else if (wake) begin
      sleeping <= 1'b0;
    end else if (sleep_enter && st == ST_RUN) begin
      sleeping <= 1'b1;
    end
  end

  // Pull-up follows the pin select; the pin is never driven
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      weak_pullup_en <= 1'b0;
      brownout_detect_en <= 1'b0;
    end else begin
      weak_pullup_en <= sel_s;
      brownout_detect_en <= bor_en;
    end
  end

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  logic ap_ok;
  logic wr_pend;
  logic [31:0] wr_addr;
  logic [7:0] keep_reg;
  logic power_control_flags_por, power_control_flags_bor, st_to, st_pd;

  assign ap_ok = hsel && hready && htrans[1];

  // Zero wait: read data is fetched in the address phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= ap_ok && hwrite;
      wr_addr <= haddr;
      hrdata <= 32'h0000_0000;
      if (ap_ok && !hwrite) begin
        if (hit(haddr, IDX_POWER_CONTROL_FLAGS)) begin
          hrdata <= {30'h0, power_control_flags_por, power_control_flags_bor};
        end else if (hit(haddr, IDX_STATUS)) begin
          hrdata <= {27'h0, st_to, st_pd, 3'h0};
        end else if (hit(haddr, IDX_KEEP)) begin
          hrdata <= {24'h0, keep_reg};
        end else if (hit(haddr, IDX_CAL)) begin
          hrdata <= {24'h0, calib_word};
        end
      end
    end
  end

  // Only system power-on clears it; sequencer resets leave it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      keep_reg <= KEEP_RST;
    end else if (wr_pend && hit(wr_addr, IDX_KEEP)) begin
      keep_reg <= hwdata[7:0];
    end
  end

  // Hardware events are assigned last so they beat a software write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_control_flags_por <= POWER_CONTROL_FLAGS_POR_RST;
      power_control_flags_bor <= POWER_CONTROL_FLAGS_BOR_RST;
      st_to <= STAT_RST;
      st_pd <= STAT_RST;
    end else begin
      if (wr_pend && hit(wr_addr, IDX_POWER_CONTROL_FLAGS)) begin
        power_control_flags_por <= hwdata[POWER_CONTROL_FLAGS_POR_BIT];
        power_control_flags_bor <= hwdata[POWER_CONTROL_FLAGS_BOR_BIT];
      end
      if (sleep_enter && st == ST_RUN && !sleeping) begin
        st_to <= 1'b1;
        st_pd <= 1'b0;
      end
      if (por_evt) begin
        power_control_flags_por <= 1'b0;
        st_to <= 1'b1;
        st_pd <= 1'b1;
      end else if (bor_evt) begin
        power_control_flags_bor <= 1'b0;
        st_to <= 1'b1;
        st_pd <= 1'b1;
      end else if (wdt_rst) begin
        st_to <= 1'b0;
      end else if (wake) begin
        st_to <= 1'b0;
        st_pd <= 1'b0;
      end else if (pin_evt && sleeping) begin
        st_to <= 1'b1;
        st_pd <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_pin_free;
    (st == ST_PIN) && !pin_low;
  endsequence
  sequence s_run_out;
    (st == ST_RUN) ##1 !core_reset;
  endsequence

  a_pin_release: assert property (
    s_pin_free |=> s_run_out)
    else $error("pin release did not start execution");
  a_pin_filter: assert property (
    $rose(pin_low) |-> $past(sel_s && !pin_s) && (pin_cnt != 12'h000))
    else $error("pin reset without filter time");
  a_por_flags: assert property (
    por_evt |=> !power_control_flags_por && st_to && st_pd)
    else $error("power-on flags wrong");
  a_bor_flag: assert property (
    bor_evt |=> !power_control_flags_bor && st_to && st_pd && (st == ST_HOLD))
    else $error("brown-out flag not cleared");
  a_wake_clean: assert property (
    wake |=> !core_reset && !st_to && !st_pd)
    else $error("watchdog wake reset the core");
  a_wdt_reset: assert property (
    wdt_rst |=> core_reset && !st_to ##1 core_reset)
    else $error("watchdog reset missing");
  a_power_up_timer_restart: assert property (
    (st == ST_POWER_UP_TIMER) && bor_evt |=> (st == ST_HOLD) ##1 power_up_timer_cnt == 0)
    else $error("timer not restarted by brown-out");
  a_supply_hold: assert property (
    (st == ST_HOLD) && !hold_ok |=> (st == ST_HOLD) && core_reset)
    else $error("left hold with supply low");
  a_ost_only_xtal: assert property (
    (st == ST_OST) |-> is_xtal(mode_s) && (ost_cnt < 11'h400))
    else $error("start-up count outside crystal mode");
  a_bor_filter: assert property (
    $rose(bor_low) |-> $past(!supply_ok, 1) && bor_en)
    else $error("brown-out without low supply");
  a_calib_keep: assert property (
    cal_done |=> $stable(calib_word))
    else $error("calibration word changed");
  a_pullup_sel: assert property (
    ##1 weak_pullup_en == $past(sel_s))
    else $error("pull-up not following pin select");
endmodule
`default_nettype wire

// >>> rts_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module rts_far_side (
  input wire logic sys_clk,
  input wire logic pull_en,
  input wire logic drive_low,
  input wire logic supply_ok,
  input wire logic por_active,
  output logic pin,
  output logic pod,
  output logic sup,
  output logic osc
);
  logic [1:0] div = 2'h0;
  logic flt = 1'b0;
  logic osc_q = 1'b0;
  // Crystal runs free at one sixth of the system clock
  always @(posedge sys_clk) begin
    div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
    if (div == 2'h2) begin
      osc_q <= ~osc_q;
    end
    flt <= ~flt;
  end
  assign osc = osc_q;
  // Released pin without pull-up floats; a toggling level shows it is undefined
  assign pin = drive_low ? 1'b0 : (pull_en ? 1'b1 : flt);
  assign pod = por_active;
  assign sup = supply_ok;
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rts_pkg::*;
  localparam int PW = 50;
  localparam int OSTC = OST_PERIODS * 6;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, core_reset, clock_stall, weak_pullup_en, brownout_detect_en;
  logic [31:0] hrdata;
  logic [7:0] calib_word;
  logic [7:0] fuse = 8'h0;
  logic sel = 1'b1;
  logic pdis = 1'b0;
  logic [1:0] bmode = 2'h1;
  logic [2:0] omode = 3'h1;
  logic wdt = 1'b0;
  logic slp = 1'b0;
  logic pin_low = 1'b0;
  logic sup_ok = 1'b1;
  logic por = 1'b1;
  logic pin, pod, sup, osc;
  logic [31:0] seed = 32'hd6f2d04e;
  logic [31:0] rd;
  logic [31:0] keep;
  logic [1:0] tp = 2'b11;
  int errors = 0;
  int num_checks = 0;
  int n;

  // Free-running system clock, 8 ns
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  rts_sequencer #(.POWER_UP_TIMER_CYCLES(PW)) u_rts_sequencer (.sys_clk, .nrst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .external_reset_pin(pin), .power_on_detect(pod), .supply_above_threshold(sup),
    .osc_clk_in(osc), .external_reset_pin_select(sel), .power_up_timer_disable_bit(pdis),
    .brownout_mode_select(bmode), .osc_mode(omode), .calib_fuse(fuse),
    .watchdog_timeout(wdt), .sleep_enter(slp), .core_reset, .clock_stall,
    .weak_pullup_en, .brownout_detect_en, .calib_word);

  rts_far_side u_rts_far_side (.sys_clk, .pull_en(weak_pullup_en), .drive_low(pin_low),
    .supply_ok(sup_ok), .por_active(por), .pin, .pod, .sup, .osc);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expired and sleep flags after each kind of reset
  function automatic logic [1:0] tp_next(input int cause, input logic [1:0] p);
    case (cause)
      0: return 2'b11;
      1: return {1'b0, p[0]};
      2: return 2'b00;
      3: return 2'b10;
      default: return p;
    endcase
  endfunction

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // Sample just before the edge, so a flop updating on it cannot race the read
  task automatic rdy();
    int k;
    for (k = 0; k < 40; k++) begin
      @(negedge sys_clk);
      rd = hrdata;
      if (hreadyout === 1'b1) break;
    end
    @(posedge sys_clk);
    if (k == 40) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] msk, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd & msk, exp);
  endtask

  task automatic flags();
    rdchk(IDX_STATUS, 32'h18, {27'h0, tp, 3'h0});
  endtask

  // Bounded wait for core reset (or stall) to reach a level; n holds the cycles
  task automatic wait_for(input bit stall, input logic v, input int bound);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while ((stall ? clock_stall : core_reset) !== v && n < bound);
    @(posedge sys_clk);
    if (n >= bound) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic pulse(input bit w);
    if (w) wdt <= 1'b1;
    else slp <= 1'b1;
    @(posedge sys_clk);
    wdt <= 1'b0;
    slp <= 1'b0;
  endtask

  task automatic hold_pin(input int k);
    pin_low <= 1'b1;
    cyc(k);
    pin_low <= 1'b0;
  endtask

  task automatic dip(input int k);
    sup_ok <= 1'b0;
    cyc(k);
    sup_ok <= 1'b1;
  endtask

  task automatic rst_cyc(input logic [2:0] m, input logic d);
    nrst <= 1'b0;
    omode <= m;
    pdis <= d;
    cyc(16);
    nrst <= 1'b1;
    tp = 2'b11;
  endtask

  task automatic pwr_cycle(input logic [2:0] m, input logic d, input int lo, input int hi);
    rst_cyc(m, d);
    wait_for(0, 1'b0, hi);
    chk(32'(n >= lo), 1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rd = xs();
    fuse = rd[7:0];
    cyc(16);
    nrst <= 1'b1;
    cyc(100);
    chk(32'(core_reset), 1);
    por <= 1'b0;
    wait_for(0, 1'b0, PW + OSTC + 60);
    // First oscillator edge may fall up to one period early
    chk(32'(n >= PW + OSTC - 6), 1);
    chk(32'(calib_word), 32'(fuse));
    flags();
    rdchk(IDX_POWER_CONTROL_FLAGS, 32'h3, 32'h0);
    bus(1'b1, IDX_POWER_CONTROL_FLAGS, 32'h3);
    rdchk(IDX_POWER_CONTROL_FLAGS, 32'h3, 32'h3);
    bus(1'b1, IDX_CAL, ~32'(fuse));
    rdchk(IDX_CAL, 32'hff, 32'(fuse));
    rdchk(8'h55, 32'hffffffff, 32'h0);
    keep = xs() & 32'hff;
    bus(1'b1, IDX_KEEP, keep);
    // Pin: random glitch below the filter, then a real reset
    hold_pin(20 + xs() % 200);
    cyc(10);
    chk(32'(core_reset), 0);
    hold_pin(300);
    chk(32'(core_reset), 1);
    wait_for(0, 1'b0, 30);
    tp = tp_next(4, tp);
    flags();
    rdchk(IDX_POWER_CONTROL_FLAGS, 32'h3, 32'h3);
    rdchk(IDX_KEEP, 32'hff, keep);
    // Watchdog reset while running
    pulse(1'b1);
    wait_for(0, 1'b1, 8);
    chk(32'(pin), 1);
    wait_for(0, 1'b0, 30);
    tp = tp_next(1, tp);
    flags();
    rdchk(IDX_KEEP, 32'hff, keep);
    // Sleep, then watchdog wake with crystal start-up
    bmode <= 2'h2;
    pulse(1'b0);
    cyc(6);
    chk(32'(brownout_detect_en), 0);
    pulse(1'b1);
    wait_for(1, 1'b1, 8);
    chk(32'(core_reset), 0);
    wait_for(1, 1'b0, OSTC + 40);
    chk(32'(n >= OSTC - 10), 1);
    cyc(6);
    chk(32'(brownout_detect_en), 1);
    tp = tp_next(2, tp);
    flags();
    rdchk(IDX_KEEP, 32'hff, keep);
    // Sleep, then pin reset
    pulse(1'b0);
    hold_pin(300);
    wait_for(0, 1'b0, 30);
    tp = tp_next(3, tp);
    flags();
    // Every brown-out mode against a long dip
    for (int m = 0; m < 4; m++) begin
      bmode <= 2'(m);
      cyc(6);
      chk(32'(brownout_detect_en), 32'(m != 0));
      dip(40);
      cyc(4);
      chk(32'(core_reset), 32'(m != 0));
      wait_for(0, 1'b0, PW + OSTC + 80);
    end
    tp = tp_next(0, tp);
    flags();
    rdchk(IDX_POWER_CONTROL_FLAGS, 32'h3, 32'h2);
    // Short dip ignored; a dip during the timer restarts the full count
    bus(1'b1, IDX_POWER_CONTROL_FLAGS, 32'h3);
    dip(2 + xs() % 8);
    cyc(20);
    chk(32'(core_reset), 0);
    dip(40);
    cyc(PW / 2 + 4);
    dip(40);
    wait_for(0, 1'b0, PW + OSTC + 80);
    chk(32'(n >= PW + OSTC), 1);
    // Pin select off: pull-up off and a floating or low pin is ignored
    sel <= 1'b0;
    cyc(6);
    chk(32'(weak_pullup_en), 0);
    hold_pin(300);
    cyc(2);
    chk(32'(core_reset), 0);
    sel <= 1'b1;
    // Start-up delay per oscillator mode and timer disable
    pwr_cycle(3'h0, 1'b1, OSTC, OSTC + 40);
    pwr_cycle(3'h2, 1'b0, PW + OSTC, PW + OSTC + 60);
    pwr_cycle(3'h5, 1'b0, PW, PW + 40);
    pwr_cycle(3'h3, 1'b1, 0, 12);
    rdchk(IDX_POWER_CONTROL_FLAGS, 32'h2, 32'h0);
    flags();
    // Pin held low past all delays: release starts at once
    pin_low <= 1'b1;
    rst_cyc(3'h1, 1'b0);
    cyc(PW + OSTC + 100);
    chk(32'(core_reset), 1);
    pin_low <= 1'b0;
    wait_for(0, 1'b0, 12);
    complete_run();
  end
endmodule
`default_nettype wire
